//--- src/phb_bridge.sv
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps

module phb_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } phb_fifo_state_t;

  phb_fifo_state_t f_q;
  phb_fifo_state_t f_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (f_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (f_q.cnt != '0);
  assign out_data = mem[f_q.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    f_d = f_q;
    if (push) begin
      f_d.wp = f_q.wp + 1'b1;
    end
    if (pop) begin
      f_d.rp = f_q.rp + 1'b1;
    end
    if (push && !pop) begin
      f_d.cnt = f_q.cnt + 1'b1;
    end else if (pop && !push) begin
      f_d.cnt = f_q.cnt - 1'b1;
    end
    if (sys_rst) begin
      f_d = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    f_q <= f_d;
    if (push) begin
      mem[f_q.wp] <= in_data;
    end
  end
endmodule

// How it works
// - memory cycles below the region limit are claimed with device select.
// - only memory commands are claimed, never i/o, configuration or others.
// - our forwarded cycles sample device select to see if a target claimed.
// - as initiator we assert cycle frame to open each transaction.
// - the target watches frame for the start and length of foreign cycles.
// - grants change on the rising edge; a granted master waits for idle bus.
// - in 66 MHz mode only the three lowest grants are ever given.
// - grants are always driven and all go high when nobody owns the bus.
// - at most one grant is active, naming the channel that owns the bus.
// - initiator ready is driven only with write data or room for read data.
// - in claimed cycles the target samples initiator ready per data phase.
// - parity makes low 32 data bits, low four command bits and parity even.
// - parity is generated but received parity is never checked or reported.
// - upper parity covers upper 32 data bits and upper four byte enables.
// - words move only on both readies low; address is on frame's first clock.
module phb_bridge #(
  parameter int N_GNT = phb_pkg::NUM_GNT,
  parameter int DEPTH = phb_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [phb_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bus control pins
  input wire logic frame_n_in,
  output logic frame_n_out,
  output logic frame_oe,
  input wire logic irdy_n_in,
  output logic irdy_n_out,
  output logic irdy_oe,
  input wire logic devsel_n_in,
  output logic devsel_n_out,
  output logic devsel_oe,
  input wire logic trdy_n_in,
  // address, data, command and parity pins
  input wire logic [63:0] ad_in,
  output logic [63:0] ad_out,
  output logic [1:0] ad_oe,
  input wire logic [7:0] cbe_n_in,
  output logic [7:0] cbe_n_out,
  output logic [1:0] cbe_oe,
  output logic par_out,
  output logic par_oe,
  output logic par64_out,
  output logic par64_oe,
  // arbiter
  input wire logic [N_GNT-1:0] req_n,
  output logic [N_GNT-1:0] gnt_n
);
  localparam int RW = $clog2(N_GNT);
  localparam logic [N_GNT-1:0] M66_MASK = N_GNT'((1 << phb_pkg::GNT66) - 1);

  typedef struct packed {
    logic tgt_en;
    logic m66;
    logic [31:0] limit;
    logic [31:0] iaddr;
    logic [3:0] icmd;
    logic [4:0] icount;
    logic iwide;
    logic start;
    logic [31:0] wd_hi;
    logic [31:0] rdata;
    logic [15:0] tcnt;
    logic abort;
    logic claimed;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    phb_pkg::phb_tgt_t tst;
    phb_pkg::phb_ini_t ist;
    logic [4:0] remain;
    logic [2:0] wait_cnt;
    logic dev_ok;
    logic frame_prev;
    logic [N_GNT-1:0] gnt_n;
    logic [RW-1:0] rr;
    logic frame_n;
    logic frame_oe;
    logic irdy_n;
    logic irdy_oe;
    logic devsel_n;
    logic devsel_oe;
    logic [63:0] ad;
    logic [1:0] ad_oe;
    logic [7:0] cbe_n;
    logic [1:0] cbe_oe;
    logic par;
    logic par_oe;
    logic par64;
    logic par64_oe;
  } phb_state_t;

  phb_state_t s_q;
  phb_state_t s_d;
  logic fifo_push;
  logic fifo_ready;
  logic fifo_valid;
  logic fifo_pop;
  logic [63:0] fifo_data;
  logic tgt_start;
  logic tgt_mem;
  logic [N_GNT-1:0] reqs;

  phb_fifo #(.WIDTH(64), .DEPTH(DEPTH)) u_wfifo (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(fifo_push),
    .in_ready(fifo_ready),
    .in_data({s_q.wd_hi, pwdata}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  assign tgt_start = s_q.frame_prev & ~frame_n_in;
  assign tgt_mem = (cbe_n_in[3:0] == phb_pkg::CMD_MEM_RD) ||
    (cbe_n_in[3:0] == phb_pkg::CMD_MEM_WR) ||
    (cbe_n_in[3:0] == phb_pkg::CMD_MEM_RD_MUL) ||
    (cbe_n_in[3:0] == phb_pkg::CMD_MEM_RD_LINE) ||
    (cbe_n_in[3:0] == phb_pkg::CMD_MEM_WR_INV);
  assign reqs = ~req_n & (s_q.m66 ? M66_MASK : '1);

  always_comb begin
    int k;
    logic found;
    logic [4:0] left;
    k = 0;
    found = 1'b0;
    left = '0;
    s_d = s_q;
    fifo_push = 1'b0;
    fifo_pop = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.frame_prev = frame_n_in;

    // apb access, one wait state, fifo full stalls the data write
    if (psel && penable && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.prdata = '0;
      case (paddr)
        phb_pkg::OFS_CTRL: begin
          if (pwrite) begin
            s_d.tgt_en = pwdata[phb_pkg::CTRL_TGT_EN];
            s_d.m66 = pwdata[phb_pkg::CTRL_M66];
          end
          s_d.prdata[phb_pkg::CTRL_TGT_EN] = s_q.tgt_en;
          s_d.prdata[phb_pkg::CTRL_M66] = s_q.m66;
        end
        phb_pkg::OFS_STAT: begin
          if (pwrite) begin
            s_d.abort = s_q.abort & ~pwdata[phb_pkg::STAT_ABORT];
            s_d.claimed = s_q.claimed & ~pwdata[phb_pkg::STAT_CLAIMED];
          end
          s_d.prdata[phb_pkg::STAT_BUSY] =
            s_q.start | (s_q.ist != phb_pkg::I_IDLE);
          s_d.prdata[phb_pkg::STAT_ABORT] = s_q.abort;
          s_d.prdata[phb_pkg::STAT_CLAIMED] = s_q.claimed;
          s_d.prdata[phb_pkg::STAT_FIFO_EMPTY] = ~fifo_valid;
          s_d.prdata[phb_pkg::STAT_FIFO_FULL] = ~fifo_ready;
          s_d.prdata[phb_pkg::STAT_GNT_LSB +: N_GNT] = ~s_q.gnt_n;
        end
        phb_pkg::OFS_IADDR: begin
          if (pwrite) begin
            s_d.iaddr = pwdata;
          end
          s_d.prdata = s_q.iaddr;
        end
        phb_pkg::OFS_ICMD: begin
          if (pwrite && pwdata[phb_pkg::ICMD_START] && !s_q.start &&
              s_q.ist == phb_pkg::I_IDLE) begin
            s_d.icmd = pwdata[phb_pkg::ICMD_CMD_LSB +: 4];
            s_d.icount = pwdata[phb_pkg::ICMD_CNT_LSB +: 5];
            s_d.iwide = pwdata[phb_pkg::ICMD_WIDE];
            s_d.start = 1'b1;
          end
          s_d.prdata[phb_pkg::ICMD_CMD_LSB +: 4] = s_q.icmd;
          s_d.prdata[phb_pkg::ICMD_CNT_LSB +: 5] = s_q.icount;
          s_d.prdata[phb_pkg::ICMD_WIDE] = s_q.iwide;
          s_d.prdata[phb_pkg::ICMD_START] = s_q.start;
        end
        phb_pkg::OFS_WDLO: begin
          fifo_push = pwrite;
          s_d.pready = ~pwrite | fifo_ready;
        end
        phb_pkg::OFS_WDHI: begin
          if (pwrite) begin
            s_d.wd_hi = pwdata;
          end
          s_d.prdata = s_q.wd_hi;
        end
        phb_pkg::OFS_TCNT: begin
          if (pwrite) begin
            s_d.tcnt = '0;
          end
          s_d.prdata[15:0] = s_q.tcnt;
        end
        phb_pkg::OFS_RDATA: s_d.prdata = s_q.rdata;
        phb_pkg::OFS_LIMIT: begin
          if (pwrite) begin
            s_d.limit = pwdata;
          end
          s_d.prdata = s_q.limit;
        end
        default: s_d.pslverr = 1'b1;
      endcase
    end

    // arbiter, grants leave on the edge and hold while requested, but all drop while our own cycle is pending or running
    if (s_q.start || s_q.ist != phb_pkg::I_IDLE) begin
      s_d.gnt_n = '1;
    end else if (~s_q.gnt_n != '0) begin
      if ((~s_q.gnt_n & reqs) == '0) begin
        s_d.gnt_n = '1;
      end
    end else begin
      for (int i = 0; i < N_GNT; i++) begin
        k = (int'(s_q.rr) + 1 + i) % N_GNT;
        if (!found && reqs[k]) begin
          found = 1'b1;
          s_d.gnt_n = ~(N_GNT'(1) << k);
          s_d.rr = RW'(k);
        end
      end
    end

    // target: claim memory cycles below the limit
    unique case (s_q.tst)
      phb_pkg::T_IDLE: begin
        if (tgt_start && tgt_mem && s_q.tgt_en &&
            s_q.ist == phb_pkg::I_IDLE && ad_in[31:0] < s_q.limit) begin
          s_d.tst = phb_pkg::T_CLAIM;
          s_d.devsel_n = 1'b0;
          s_d.devsel_oe = 1'b1;
        end
      end
      phb_pkg::T_CLAIM: begin
        if (!irdy_n_in && !trdy_n_in) begin
          s_d.tcnt = s_d.tcnt + 16'h1;
          if (frame_n_in) begin
            s_d.tst = phb_pkg::T_TURN;
            s_d.devsel_n = 1'b1;
          end
        end
      end
      phb_pkg::T_TURN: begin
        s_d.tst = phb_pkg::T_IDLE;
        s_d.devsel_oe = 1'b0;
      end
      default: s_d.tst = phb_pkg::T_IDLE;
    endcase

    // initiator
    unique case (s_q.ist)
      phb_pkg::I_IDLE: begin
        if (s_q.start && frame_n_in && irdy_n_in && s_q.gnt_n == '1 &&
            s_q.tst == phb_pkg::T_IDLE) begin
          s_d.start = 1'b0;
          s_d.ist = phb_pkg::I_ADDR;
          s_d.frame_n = 1'b0;
          s_d.frame_oe = 1'b1;
          s_d.irdy_n = 1'b1;
          s_d.irdy_oe = 1'b1;
          s_d.ad = {32'h0000_0000, s_q.iaddr};
          s_d.ad_oe = 2'b01;
          s_d.cbe_n = {4'hF, s_q.icmd};
          s_d.cbe_oe = {s_q.iwide, 1'b1};
          s_d.remain = (s_q.icount == '0) ? 5'h01 : s_q.icount;
          s_d.wait_cnt = '0;
          s_d.dev_ok = 1'b0;
        end
      end
      phb_pkg::I_ADDR: begin
        s_d.ist = phb_pkg::I_DATA;
        s_d.cbe_n = 8'h00;
        if (s_q.icmd[0]) begin
          s_d.ad_oe = {s_q.iwide, 1'b1};
          if (fifo_valid) begin
            fifo_pop = 1'b1;
            s_d.ad = fifo_data;
            s_d.irdy_n = 1'b0;
            s_d.frame_n = (s_q.remain == 5'h01);
          end
        end else begin
          s_d.ad_oe = 2'b00;
          s_d.irdy_n = 1'b0;
          s_d.frame_n = (s_q.remain == 5'h01);
        end
      end
      phb_pkg::I_DATA: begin
        if (!devsel_n_in) begin
          s_d.dev_ok = 1'b1;
          s_d.claimed = 1'b1;
        end
        if (!s_q.dev_ok && devsel_n_in) begin
          s_d.wait_cnt = s_q.wait_cnt + 3'h1;
          if (s_q.wait_cnt == 3'(phb_pkg::ABORT_CYC - 1)) begin
            s_d.abort = 1'b1;
            s_d.ist = phb_pkg::I_TURN;
            s_d.frame_n = 1'b1;
            s_d.irdy_n = 1'b1;
          end
        end
        if (!s_q.irdy_n && !trdy_n_in && !devsel_n_in) begin
          if (!s_q.icmd[0]) begin
            s_d.rdata = ad_in[31:0];
          end
          left = s_q.remain - 5'h01;
          s_d.remain = left;
          if (left == '0) begin
            s_d.ist = phb_pkg::I_TURN;
            s_d.irdy_n = 1'b1;
            s_d.frame_n = 1'b1;
          end else if (s_q.icmd[0]) begin
            s_d.irdy_n = ~fifo_valid;
            if (fifo_valid) begin
              fifo_pop = 1'b1;
              s_d.ad = fifo_data;
              s_d.frame_n = (left == 5'h01);
            end
          end else begin
            s_d.frame_n = (left == 5'h01);
          end
        end else if (s_q.irdy_n && s_q.icmd[0] && fifo_valid &&
                     s_d.ist == phb_pkg::I_DATA) begin
          fifo_pop = 1'b1;
          s_d.ad = fifo_data;
          s_d.irdy_n = 1'b0;
          s_d.frame_n = (s_q.remain == 5'h01);
        end
      end
      phb_pkg::I_TURN: begin
        s_d.ist = phb_pkg::I_IDLE;
        s_d.frame_oe = 1'b0;
        s_d.irdy_oe = 1'b0;
        s_d.ad_oe = 2'b00;
        s_d.cbe_oe = 2'b00;
      end
    endcase

    // parity one clock behind what it covers; received parity ignored
    s_d.par = ^{s_q.ad[31:0], s_q.cbe_n[3:0]};
    s_d.par_oe = s_q.ad_oe[0];
    s_d.par64 = ^{s_q.ad[63:32], s_q.cbe_n[7:4]};
    s_d.par64_oe = s_q.ad_oe[1];

    if (sys_rst) begin
      s_d = '0;
      s_d.limit = phb_pkg::LIMIT_RST;
      s_d.gnt_n = '1;
      s_d.frame_n = 1'b1;
      s_d.irdy_n = 1'b1;
      s_d.devsel_n = 1'b1;
      s_d.cbe_n = '1;
      s_d.frame_prev = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    s_q <= s_d;
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign frame_n_out = s_q.frame_n;
  assign frame_oe = s_q.frame_oe;
  assign irdy_n_out = s_q.irdy_n;
  assign irdy_oe = s_q.irdy_oe;
  assign devsel_n_out = s_q.devsel_n;
  assign devsel_oe = s_q.devsel_oe;
  assign ad_out = s_q.ad;
  assign ad_oe = s_q.ad_oe;
  assign cbe_n_out = s_q.cbe_n;
  assign cbe_oe = s_q.cbe_oe;
  assign par_out = s_q.par;
  assign par_oe = s_q.par_oe;
  assign par64_out = s_q.par64;
  assign par64_oe = s_q.par64_oe;
  assign gnt_n = s_q.gnt_n;

  chk_gnt_onehot: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $onehot0(~gnt_n)) else $error("two grants active");
  chk_gnt_m66_mask: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_q.m66 |=> &gnt_n[N_GNT-1:phb_pkg::GNT66])
    else $error("upper grant given in 66 mode");
  chk_gnt_release: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (~gnt_n != '0) && ((~gnt_n & reqs) == '0) |=> gnt_n == '1)
    else $error("grant kept without request");
  chk_devsel_claim: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_q.tst == phb_pkg::T_IDLE && tgt_start && tgt_mem && s_q.tgt_en &&
    s_q.ist == phb_pkg::I_IDLE && ad_in[31:0] < s_q.limit
    |=> !devsel_n_out && devsel_oe) else $error("memory cycle not claimed");
  chk_no_io_claim: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_q.tst == phb_pkg::T_IDLE && !tgt_mem |=> devsel_n_out)
    else $error("non memory cycle claimed");
  chk_par_even: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ad_oe[0] |=> par_oe && !(par_out ^ (^$past(s_q.ad[31:0])) ^
    (^$past(s_q.cbe_n[3:0])))) else $error("low parity wrong");
  chk_par64_even: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ad_oe[1] |=> par64_oe && !(par64_out ^ (^$past(s_q.ad[63:32])) ^
    (^$past(s_q.cbe_n[7:4])))) else $error("upper parity wrong");
  chk_frame_start: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $rose(s_q.ist == phb_pkg::I_ADDR) |-> !frame_n_out && frame_oe && ad_oe[0]
    ##1 s_q.ist == phb_pkg::I_DATA) else $error("frame not opened");
  chk_irdy_write: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_q.ist == phb_pkg::I_DATA && !irdy_n_out && s_q.icmd[0] |-> ad_oe[0])
    else $error("ready without write data");
  chk_tcnt_count: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_q.tst == phb_pkg::T_CLAIM && !irdy_n_in && !trdy_n_in &&
    !(psel && penable && !pready && paddr == phb_pkg::OFS_TCNT)
    |=> s_q.tcnt == $past(s_q.tcnt) + 16'h1) else $error("phase missed");
  chk_abort_bound: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (s_q.ist == phb_pkg::I_DATA && !s_q.dev_ok && devsel_n_in)[*5]
    |=> s_q.ist == phb_pkg::I_TURN && s_q.abort)
    else $error("no master abort");
  chk_reset_idle: assert property (
    @(posedge core_clk)
    sys_rst |=> gnt_n == '1 && devsel_n_out && irdy_n_out && !pready)
    else $error("outputs active after reset");
endmodule

//--- src/phb_pkg.sv
package phb_pkg;
  // apb register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IADDR = 8'h08;
  localparam logic [7:0] OFS_ICMD = 8'h0C;
  localparam logic [7:0] OFS_WDLO = 8'h10;
  localparam logic [7:0] OFS_WDHI = 8'h14;
  localparam logic [7:0] OFS_TCNT = 8'h18;
  localparam logic [7:0] OFS_RDATA = 8'h1C;
  localparam logic [7:0] OFS_LIMIT = 8'h9C;

  // reset values
  localparam logic [31:0] LIMIT_RST = 32'h0000_0000;

  // control fields
  localparam int CTRL_TGT_EN = 0;
  localparam int CTRL_M66 = 1;

  // initiator command fields
  localparam int ICMD_CMD_LSB = 0;
  localparam int ICMD_CNT_LSB = 4;
  localparam int ICMD_WIDE = 9;
  localparam int ICMD_START = 31;

  // status fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_ABORT = 1;
  localparam int STAT_CLAIMED = 2;
  localparam int STAT_FIFO_EMPTY = 3;
  localparam int STAT_FIFO_FULL = 4;
  localparam int STAT_GNT_LSB = 8;

  // bus commands claimed by the target
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_MEM_RD_MUL = 4'hC;
  localparam logic [3:0] CMD_MEM_RD_LINE = 4'hE;
  localparam logic [3:0] CMD_MEM_WR_INV = 4'hF;

  // arbiter
  localparam int NUM_GNT = 7;
  localparam int GNT66 = 3;

  // fifo
  localparam int FIFO_DEPTH = 16;

  // timing
  localparam int CLK_NS = 50;
  localparam int ABORT_NS = 250;
  localparam int ABORT_CYC = (ABORT_NS / CLK_NS < 1) ? 1 : ABORT_NS / CLK_NS;

  typedef enum logic [1:0] {T_IDLE, T_CLAIM, T_TURN} phb_tgt_t;
  typedef enum logic [1:0] {I_IDLE, I_ADDR, I_DATA, I_TURN} phb_ini_t;
endpackage

//--- testbench/phb_pci_agent.sv
`timescale 1ns/1ps

module phb_pci_agent (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // resolved bus levels
  input wire logic frame_n,
  input wire logic irdy_n,
  // target side
  input wire logic answer,
  input wire logic slow,
  output logic devsel_n,
  output logic trdy_n,
  // master side
  output logic m_trdy_n,
  output logic m_oe,
  output logic m_frame_n,
  output logic m_irdy_n,
  output logic [63:0] m_ad,
  output logic [7:0] m_cbe_n
);
  logic frame_q;
  logic act;
  logic ph;
  localparam logic [31:0] RD_WORD = 32'h5A5A_C3C3;

  initial begin
    devsel_n = 1'b1;
    trdy_n = 1'b1;
    m_trdy_n = 1'b1;
    m_oe = 1'b0;
    m_frame_n = 1'b1;
    m_irdy_n = 1'b1;
    m_ad = 64'h0;
    m_cbe_n = 8'hFF;
  end

  // target for our cycles, read word on claim, stalls when slow
  always @(posedge core_clk) begin
    frame_q <= frame_n;
    if (sys_rst) begin
      act <= 1'b0;
      ph <= 1'b0;
      devsel_n <= 1'b1;
      trdy_n <= 1'b1;
    end else if (!act) begin
      if (frame_q && !frame_n && !m_oe && answer) begin
        act <= 1'b1;
        m_ad <= {32'h0, RD_WORD};
      end
    end else if (!irdy_n && !trdy_n && frame_n) begin
      act <= 1'b0;
      devsel_n <= 1'b1;
      trdy_n <= 1'b1;
    end else begin
      devsel_n <= 1'b0;
      ph <= ~ph;
      trdy_n <= slow & ph;
    end
  end

  // foreign master, memory side answers every phase
  task automatic mem_cycle(input logic [3:0] cmd, input logic [31:0] adr,
                           input int n);
    while (!(frame_n && irdy_n)) @(posedge core_clk);
    m_oe <= 1'b1;
    m_frame_n <= 1'b0;
    m_ad <= {32'h0, adr};
    m_cbe_n <= {4'hF, cmd};
    @(posedge core_clk);
    m_cbe_n <= 8'h00;
    m_irdy_n <= 1'b0;
    m_trdy_n <= 1'b0;
    m_frame_n <= (n == 1);
    for (int i = 1; i < n; i++) begin
      @(posedge core_clk);
      m_frame_n <= (i == n - 1);
    end
    @(posedge core_clk);
    m_frame_n <= 1'b1;
    m_irdy_n <= 1'b1;
    m_trdy_n <= 1'b1;
    m_ad <= ~m_ad;
    m_cbe_n <= ~m_cbe_n;
    @(posedge core_clk);
    m_oe <= 1'b0;
  endtask
endmodule

//--- testbench/pci_host_bridge_bus_signals_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin \
  compares++; \
  if ((a) !== (e)) begin \
    bad_count++; \
    $display("ERROR %s exp %0h got %0h", n, e, a); \
  end \
end

module pci_host_bridge_bus_signals_tb;
  localparam logic [31:0] LIM = 32'h0010_0000;
  localparam logic [31:0] IADR = 32'h2000_0000;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, cbe_n_in, cbe_n_out, m_cbe_n, p_cbe;
  logic [31:0] pwdata, prdata, rv;
  logic frame_n_in, frame_n_out, frame_oe, irdy_n_in, irdy_n_out, irdy_oe;
  logic devsel_n_in, devsel_n_out, devsel_oe, trdy_n_in, answer, slow;
  logic [63:0] ad_in, ad_out, m_ad, p_ad;
  logic [1:0] ad_oe, cbe_oe, p_oe;
  logic par_out, par_oe, par64_out, par64_oe, p_frm;
  logic t_devsel_n, t_trdy_n, m_trdy_n, m_oe, m_frame_n, m_irdy_n;
  logic [6:0] req_n, gnt_n;
  int bad_count, compares, cyc, words;

  assign frame_n_in = frame_oe ? frame_n_out : m_frame_n;
  assign irdy_n_in = irdy_oe ? irdy_n_out : m_irdy_n;
  assign devsel_n_in = devsel_oe ? devsel_n_out : t_devsel_n;
  assign trdy_n_in = t_trdy_n & m_trdy_n;
  assign ad_in = {ad_oe[1] ? ad_out[63:32] : m_ad[63:32],
                  ad_oe[0] ? ad_out[31:0] : m_ad[31:0]};
  assign cbe_n_in = {cbe_oe[1] ? cbe_n_out[7:4] : m_cbe_n[7:4],
                     cbe_oe[0] ? cbe_n_out[3:0] : m_cbe_n[3:0]};

  phb_bridge u_dut (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .frame_n_in, .frame_n_out,
    .frame_oe, .irdy_n_in, .irdy_n_out, .irdy_oe, .devsel_n_in,
    .devsel_n_out, .devsel_oe, .trdy_n_in, .ad_in, .ad_out, .ad_oe,
    .cbe_n_in, .cbe_n_out, .cbe_oe, .par_out, .par_oe, .par64_out,
    .par64_oe, .req_n, .gnt_n);

  phb_pci_agent u_agent (.core_clk, .sys_rst, .frame_n(frame_n_in),
    .irdy_n(irdy_n_in), .answer, .slow, .devsel_n(t_devsel_n),
    .trdy_n(t_trdy_n), .m_trdy_n, .m_oe, .m_frame_n, .m_irdy_n, .m_ad,
    .m_cbe_n);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // bus monitor and cycle ceiling
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test;
    end
    if (!sys_rst) begin
      `CHK("par_oe", p_oe[0], par_oe)
      if (p_oe[0]) `CHK("par", ^{p_ad[31:0], p_cbe[3:0]}, par_out)
      if (p_oe[1])
        `CHK("par64", ^{p_ad[63:32], p_cbe[7:4]}, par64_out)
      `CHK("onehot", 1'b1, $countones(~gnt_n) <= 1)
    end
    if (frame_oe && !frame_n_out && !p_frm)
      `CHK("addr", IADR, ad_out[31:0])
    if (irdy_oe && !irdy_n_out && !trdy_n_in && !devsel_n_in && ad_oe[0]) begin
      `CHK("wdata", 32'h100 + words, ad_out[31:0])
      `CHK("wdhi", 32'hA5A5_0000, ad_out[63:32])
      words++;
    end
    p_frm <= frame_oe && !frame_n_out;
    p_ad <= ad_out;
    p_cbe <= cbe_n_out;
    p_oe <= ad_oe;
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task idle;
    rv = 32'h1;
    while (rv[phb_pkg::STAT_BUSY] !== 1'b0) rd(phb_pkg::OFS_STAT);
  endtask

  task t_reset;
    `CHK("gnt", 7'h7F, gnt_n)
    `CHK("oe", 3'h0, {frame_oe, irdy_oe, devsel_oe})
    rd(phb_pkg::OFS_LIMIT);
    `CHK("limit", phb_pkg::LIMIT_RST, rv)
    wr(phb_pkg::OFS_LIMIT, LIM);
    rd(phb_pkg::OFS_LIMIT);
    `CHK("limit_rw", LIM, rv)
    rd(8'h40);
    `CHK("slverr", 1'b1, err)
  endtask

  task t_target;
    logic [3:0] c;
    logic [31:0] a;
    logic hit;
    wr(phb_pkg::OFS_CTRL, 32'h1);
    for (int i = 0; i < 18; i++) begin
      c = (i < 16) ? 4'(i) : phb_pkg::CMD_MEM_WR;
      a = (i == 16) ? LIM : (i == 17) ? 32'h0 : LIM - 32'h4;
      hit = (a < LIM) && (c inside {phb_pkg::CMD_MEM_RD, phb_pkg::CMD_MEM_WR,
        phb_pkg::CMD_MEM_RD_MUL, phb_pkg::CMD_MEM_RD_LINE,
        phb_pkg::CMD_MEM_WR_INV});
      wr(phb_pkg::OFS_TCNT, 32'h0);
      u_agent.mem_cycle(c, a, 3);
      rd(phb_pkg::OFS_TCNT);
      `CHK("tcnt", hit ? 32'h3 : 32'h0, rv)
    end
  endtask

  task t_init;
    wr(phb_pkg::OFS_WDHI, 32'hA5A5_0000);
    for (int i = 0; i < 16; i++) wr(phb_pkg::OFS_WDLO, 32'h100 + 32'(i));
    rd(phb_pkg::OFS_STAT);
    `CHK("full", 1'b1, rv[phb_pkg::STAT_FIFO_FULL])
    slow <= 1'b1;
    wr(phb_pkg::OFS_IADDR, IADR);
    wr(phb_pkg::OFS_ICMD, 32'h8000_0307);
    idle;
    `CHK("words", 16, words)
    `CHK("empty", 1'b1, rv[phb_pkg::STAT_FIFO_EMPTY])
    `CHK("claimed", 1'b1, rv[phb_pkg::STAT_CLAIMED])
    answer <= 1'b0;
    wr(phb_pkg::OFS_STAT, 32'h6);
    wr(phb_pkg::OFS_WDLO, 32'h110);
    wr(phb_pkg::OFS_ICMD, 32'h8000_0007);
    idle;
    `CHK("abort", 2'h1, rv[2:1])
    `CHK("nodata", 16, words)
    answer <= 1'b1;
    wr(phb_pkg::OFS_ICMD, 32'h8000_0006);
    idle;
    rd(phb_pkg::OFS_RDATA);
    `CHK("rdata", 32'h5A5A_C3C3, rv)
  endtask

  task t_arb;
    req_n <= 7'h6F;
    repeat (4) @(posedge core_clk);
    `CHK("gnt4", 7'h6F, gnt_n)
    req_n <= 7'h6A;
    repeat (4) @(posedge core_clk);
    `CHK("hold", 7'h6F, gnt_n)
    req_n <= 7'h7F;
    repeat (4) @(posedge core_clk);
    `CHK("none", 7'h7F, gnt_n)
    wr(phb_pkg::OFS_CTRL, 32'h3);
    req_n <= 7'h0F;
    repeat (4) @(posedge core_clk);
    `CHK("m66", 7'h7F, gnt_n)
    req_n <= 7'h0B;
    repeat (4) @(posedge core_clk);
    `CHK("m66g2", 7'h7B, gnt_n)
    req_n <= 7'h7F;
  endtask

  task end_of_test;
    $display("checks %0d errors %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    req_n = 7'h7F;
    answer = 1'b1;
    slow = 1'b0;
    p_frm = 1'b0;
    p_oe = 2'h0;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    t_reset;
    t_target;
    t_init;
    t_arb;
    end_of_test;
  end
endmodule
